// >>> verilog/mep_params.svh
// Register offsets, field positions, reset values and timing figures of the motion parameter bank
`ifndef MEP_PARAMS_SVH
`define MEP_PARAMS_SVH
`define MEP_ADDR_W 8
`define MEP_OFS_FF_DELAY 8'h22
`define MEP_OFS_FF_THRESH 8'h23
`define MEP_OFS_HYST_MODE 8'h24
`define MEP_OFS_SHK_DELAY 8'h25
`define MEP_OFS_SHK_THRESH 8'h26
`define MEP_OFS_MOT_COUNT 8'h27
`define MEP_OFS_MOT_THRESH 8'h28
`define MEP_OFS_RSVD_A 8'h29
`define MEP_OFS_KNK_TIMING 8'h2a
`define MEP_OFS_KNK_SAMP_TH 8'h2b
`define MEP_OFS_TILT_CFG 8'h2c
`define MEP_OFS_TILT_ANGLE 8'h2d
`define MEP_OFS_LVL_ANGLE 8'h2e
`define MEP_OFS_LVL_HOLD 8'h2f
`define MEP_OFS_RSVD_B 8'h30
`define MEP_OFS_RSVD_C 8'h31
`define MEP_RST_FF_DELAY 8'h09
`define MEP_RST_FF_THRESH 8'h30
`define MEP_RST_FF_MODE 1'h0
`define MEP_RST_FF_HYST 2'h1
`define MEP_RST_SHK_HYST 2'h2
`define MEP_RST_SHK_DELAY 8'h0f
`define MEP_RST_SHK_THRESH 8'hc0
`define MEP_RST_MOT_COUNT 2'h0
`define MEP_RST_MOT_THRESH 8'h14
`define MEP_RST_KNK_QUIET 1'h0
`define MEP_RST_KNK_SHOCK 1'h0
`define MEP_RST_KNK_WINDOW 3'h4
`define MEP_RST_KNK_SAMP 2'h0
`define MEP_RST_KNK_THRESH 5'h0a
`define MEP_RST_TILT_HYST 3'h1
`define MEP_RST_TILT_BLOCK 2'h2
`define MEP_RST_TILT_MODE 2'h0
`define MEP_RST_TILT_ANGLE 6'h08
`define MEP_RST_LVL_ANGLE 6'h08
`define MEP_RST_LVL_HOLD 2'h1
// Field positions (low bit) inside their bytes
`define MEP_POS_FF_HYST 0
`define MEP_POS_FF_MODE 2
`define MEP_POS_SHK_HYST 6
`define MEP_POS_KNK_WINDOW 0
`define MEP_POS_KNK_SHOCK 6
`define MEP_POS_KNK_QUIET 7
`define MEP_POS_KNK_THRESH 0
`define MEP_POS_KNK_SAMP 6
`define MEP_POS_TILT_MODE 0
`define MEP_POS_TILT_BLOCK 2
`define MEP_POS_TILT_HYST 4
`define MEP_POS_LVL_HOLD 4
// Timing figures in ms
`define MEP_DELAY_STEP_MS 2
`define MEP_KNK_QUIET_LONG_MS 30
`define MEP_KNK_QUIET_SHORT_MS 20
`define MEP_KNK_SHOCK_SHORT_MS 50
`define MEP_KNK_SHOCK_LONG_MS 75
`define MEP_LVL_HOLD_STEP_MS 512
`endif

// >>> verilog/mep_pkg.sv
// Types shared by the motion parameter bank
package mep_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mep_req_s;
  typedef struct packed {
    logic [7:0] ffDelay;
    logic [7:0] ffThreshold;
    logic ffSumMode;
    logic [1:0] freefall_hysteresis;
    logic [1:0] shock_hysteresis;
    logic [7:0] shkDelay;
    logic [7:0] shock_threshold;
    logic [1:0] motCount;
    logic [7:0] motion_threshold;
    logic knkQuietShort;
    logic knkShockLong;
    logic [2:0] knkWindow;
    logic [1:0] knkSamples;
    logic [4:0] knock_threshold;
    logic [2:0] tiltHyst;
    logic [1:0] tiltBlock;
    logic [1:0] tiltMode;
    logic [5:0] tiltAngle;
    logic [5:0] lvlAngle;
    logic [1:0] lvlHold;
  } mep_cfg_s;
  typedef enum logic [1:0] {
    MEP_BLK_NONE = 2'h0,
    MEP_BLK_ANGLE = 2'h1,
    MEP_BLK_ANGLE_SLOPE = 2'h2,
    MEP_BLK_FULL = 2'h3
  } mep_block_e;
  typedef enum logic [1:0] {
    MEP_TM_SYM = 2'h0,
    MEP_TM_HIGH_ASYM = 2'h1,
    MEP_TM_LOW_ASYM = 2'h2,
    MEP_TM_SYM2 = 2'h3
  } mep_tilt_mode_e;
endpackage : mep_pkg

// >>> verilog/mep_regs.sv
// Parameter register bank for the motion-event engine
`timescale 1ns/1ns
`include "mep_params.svh"

// Operation
// - Freefall delay 8 bits, (value+1)*2 ms, resets to 0x09.
// - Freefall threshold 8 bits, 7.81 mg per count, resets to 0x30.
// - Freefall mode bit: 0 per-axis, 1 summed; resets per-axis.
// - Freefall hysteresis 2 bits, 125 mg steps, resets to 01b.
// - Shock hysteresis 2 bits, range scaled step, resets to 10b.
// - Shock delay 8 bits, (value+1)*2 ms, resets to 0x0F.
// - Shock threshold 8 bits, range scaled step, resets to 0xC0.
// - Motion sample count 2 bits, N = value+1, resets to 00b.
// - Motion threshold 8 bits in data LSBs, resets to 0x14.
// - Knock quiet bit: 30 ms cleared, 20 ms set; resets cleared.
// - Knock shock bit: 50 ms cleared, 75 ms set; resets cleared.
// - Double-knock window 3 bits, 50 to 700 ms, resets to 100b.
// - Knock samples after wake 2 bits: 2,4,8,16; resets 00b.
// - Knock threshold 5 bits, range scaled step, resets to 0x0A.
// - Tilt hysteresis 3 bits, 62.5 mg step, resets to 001b.
// - Tilt blocking selector 2 bits, four blocking kinds, resets 10b.
// - Tilt threshold mode 2 bits, sym/high/low asym, resets 00b.
// - Tilt blocking angle 6 bits, 0 to 44.8 deg, resets 0x08.
// - Level angle 6 bits, 0 to 44.8 deg, resets 0x08.
// - Level hold 2 bits: 0, 512, 1024, 2048 ms; resets 01b.
// - Reserved addresses 0x29, 0x30, 0x31 have no function.
// - Freefall event produced only one cycle after raw event and enable bit are both set.
module mep_regs #(
  parameter int CLK_HZ = 10000000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  output logic regHit,
  input wire logic ffEventEn,
  input wire logic ffEventRaw,
  output logic ffEvent,
  output mep_pkg::mep_cfg_s cfg,
  output logic [15:0] ffDelayMs,
  output logic [15:0] shkDelayMs,
  output logic [15:0] knkQuietMs,
  output logic [15:0] knkShockMs,
  output logic [15:0] knkWindowMs,
  output logic [4:0] knkSampleCount,
  output logic [2:0] motSampleCount,
  output logic [15:0] lvlHoldMs
);
  import mep_pkg::*;

  mep_cfg_s cfg_r;
  logic [7:0] rdata_r;
  logic hit_r;
  logic ffEvent_r;

  // Decode used by the read path only, for the hit flag
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a >= `MEP_OFS_FF_DELAY) && (a <= `MEP_OFS_LVL_HOLD) &&
      (a != `MEP_OFS_RSVD_A);
  endfunction : isMapped

  // Image of a register as software reads it; unused bits fixed at zero
  function automatic logic [7:0] readImage(input mep_cfg_s c, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `MEP_OFS_FF_DELAY: v = c.ffDelay;
      `MEP_OFS_FF_THRESH: v = c.ffThreshold;
      `MEP_OFS_HYST_MODE:
      begin
        v[`MEP_POS_FF_HYST +: 2] = c.freefall_hysteresis;
        v[`MEP_POS_FF_MODE] = c.ffSumMode;
        v[`MEP_POS_SHK_HYST +: 2] = c.shock_hysteresis;
      end
      `MEP_OFS_SHK_DELAY: v = c.shkDelay;
      `MEP_OFS_SHK_THRESH: v = c.shock_threshold;
      `MEP_OFS_MOT_COUNT: v[1:0] = c.motCount;
      `MEP_OFS_MOT_THRESH: v = c.motion_threshold;
      `MEP_OFS_KNK_TIMING:
      begin
        v[`MEP_POS_KNK_WINDOW +: 3] = c.knkWindow;
        v[`MEP_POS_KNK_SHOCK] = c.knkShockLong;
        v[`MEP_POS_KNK_QUIET] = c.knkQuietShort;
      end
      `MEP_OFS_KNK_SAMP_TH:
      begin
        v[`MEP_POS_KNK_THRESH +: 5] = c.knock_threshold;
        v[`MEP_POS_KNK_SAMP +: 2] = c.knkSamples;
      end
      `MEP_OFS_TILT_CFG:
      begin
        v[`MEP_POS_TILT_MODE +: 2] = c.tiltMode;
        v[`MEP_POS_TILT_BLOCK +: 2] = c.tiltBlock;
        v[`MEP_POS_TILT_HYST +: 3] = c.tiltHyst;
      end
      `MEP_OFS_TILT_ANGLE: v[5:0] = c.tiltAngle;
      `MEP_OFS_LVL_ANGLE: v[5:0] = c.lvlAngle;
      `MEP_OFS_LVL_HOLD: v[`MEP_POS_LVL_HOLD +: 2] = c.lvlHold;
      default: v = 8'h00;
    endcase
    readImage = v;
  endfunction : readImage

  // Register writes; each field keeps only its documented bits
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_r.ffDelay <= `MEP_RST_FF_DELAY;
      cfg_r.ffThreshold <= `MEP_RST_FF_THRESH;
      cfg_r.ffSumMode <= `MEP_RST_FF_MODE;
      cfg_r.freefall_hysteresis <= `MEP_RST_FF_HYST;
      cfg_r.shock_hysteresis <= `MEP_RST_SHK_HYST;
      cfg_r.shkDelay <= `MEP_RST_SHK_DELAY;
      cfg_r.shock_threshold <= `MEP_RST_SHK_THRESH;
      cfg_r.motCount <= `MEP_RST_MOT_COUNT;
      cfg_r.motion_threshold <= `MEP_RST_MOT_THRESH;
      cfg_r.knkQuietShort <= `MEP_RST_KNK_QUIET;
      cfg_r.knkShockLong <= `MEP_RST_KNK_SHOCK;
      cfg_r.knkWindow <= `MEP_RST_KNK_WINDOW;
      cfg_r.knkSamples <= `MEP_RST_KNK_SAMP;
      cfg_r.knock_threshold <= `MEP_RST_KNK_THRESH;
      cfg_r.tiltHyst <= `MEP_RST_TILT_HYST;
      cfg_r.tiltBlock <= `MEP_RST_TILT_BLOCK;
      cfg_r.tiltMode <= `MEP_RST_TILT_MODE;
      cfg_r.tiltAngle <= `MEP_RST_TILT_ANGLE;
      cfg_r.lvlAngle <= `MEP_RST_LVL_ANGLE;
      cfg_r.lvlHold <= `MEP_RST_LVL_HOLD;
    end
    else if (regWr)
    begin
      case (regAddr)
        `MEP_OFS_FF_DELAY: cfg_r.ffDelay <= regWdata;
        `MEP_OFS_FF_THRESH: cfg_r.ffThreshold <= regWdata;
        `MEP_OFS_HYST_MODE:
        begin
          cfg_r.freefall_hysteresis <= regWdata[`MEP_POS_FF_HYST +: 2];
          cfg_r.ffSumMode <= regWdata[`MEP_POS_FF_MODE];
          cfg_r.shock_hysteresis <= regWdata[`MEP_POS_SHK_HYST +: 2];
        end
        `MEP_OFS_SHK_DELAY: cfg_r.shkDelay <= regWdata;
        `MEP_OFS_SHK_THRESH: cfg_r.shock_threshold <= regWdata;
        `MEP_OFS_MOT_COUNT: cfg_r.motCount <= regWdata[1:0];
        `MEP_OFS_MOT_THRESH: cfg_r.motion_threshold <= regWdata;
        `MEP_OFS_KNK_TIMING:
        begin
          cfg_r.knkWindow <= regWdata[`MEP_POS_KNK_WINDOW +: 3];
          cfg_r.knkShockLong <= regWdata[`MEP_POS_KNK_SHOCK];
          cfg_r.knkQuietShort <= regWdata[`MEP_POS_KNK_QUIET];
        end
        `MEP_OFS_KNK_SAMP_TH:
        begin
          cfg_r.knock_threshold <= regWdata[`MEP_POS_KNK_THRESH +: 5];
          cfg_r.knkSamples <= regWdata[`MEP_POS_KNK_SAMP +: 2];
        end
        `MEP_OFS_TILT_CFG:
        begin
          cfg_r.tiltMode <= regWdata[`MEP_POS_TILT_MODE +: 2];
          cfg_r.tiltBlock <= regWdata[`MEP_POS_TILT_BLOCK +: 2];
          cfg_r.tiltHyst <= regWdata[`MEP_POS_TILT_HYST +: 3];
        end
        `MEP_OFS_TILT_ANGLE: cfg_r.tiltAngle <= regWdata[5:0];
        `MEP_OFS_LVL_ANGLE: cfg_r.lvlAngle <= regWdata[5:0];
        `MEP_OFS_LVL_HOLD: cfg_r.lvlHold <= regWdata[`MEP_POS_LVL_HOLD +: 2];
        default: cfg_r.ffDelay <= cfg_r.ffDelay;
      endcase
    end
  end

  // Read data stand for exactly one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
    end
    else if (regRd)
    begin
      rdata_r <= readImage(cfg_r, regAddr);
      hit_r <= isMapped(regAddr);
    end
    else
    begin
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
    end
  end

  // Freefall event gate; registered so it lines up with the data outputs
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ffEvent_r <= 1'b0;
    else
      ffEvent_r <= ffEventRaw & ffEventEn;
  end

  // Decoded timing in ms and sample counts for the detectors; a lookup keeps the dividers out
  always_comb
  begin
    ffDelayMs = 16'((16'(cfg_r.ffDelay) + 16'h0001) * `MEP_DELAY_STEP_MS);
    shkDelayMs = 16'((16'(cfg_r.shkDelay) + 16'h0001) * `MEP_DELAY_STEP_MS);
    knkQuietMs = cfg_r.knkQuietShort ? 16'(`MEP_KNK_QUIET_SHORT_MS)
                                     : 16'(`MEP_KNK_QUIET_LONG_MS);
    knkShockMs = cfg_r.knkShockLong ? 16'(`MEP_KNK_SHOCK_LONG_MS)
                                    : 16'(`MEP_KNK_SHOCK_SHORT_MS);
    case (cfg_r.knkWindow)
      3'h0: knkWindowMs = 16'h0032;
      3'h1: knkWindowMs = 16'h0064;
      3'h2: knkWindowMs = 16'h0096;
      3'h3: knkWindowMs = 16'h00c8;
      3'h4: knkWindowMs = 16'h00fa;
      3'h5: knkWindowMs = 16'h0177;
      3'h6: knkWindowMs = 16'h01f4;
      default: knkWindowMs = 16'h02bc;
    endcase
    knkSampleCount = 5'(5'h02 << cfg_r.knkSamples);
    motSampleCount = 3'(cfg_r.motCount) + 3'h1;
    case (cfg_r.lvlHold)
      2'h0: lvlHoldMs = 16'h0000;
      default: lvlHoldMs = 16'(`MEP_LVL_HOLD_STEP_MS << (cfg_r.lvlHold - 2'h1));
    endcase
  end

  assign cfg = cfg_r;
  assign regRdata = rdata_r;
  assign regHit = hit_r;
  assign ffEvent = ffEvent_r;
endmodule : mep_regs

// >>> tb/mep_regs_properties.sv
// Checker for the motion parameter register bank
`timescale 1ns/1ns
module mep_regs_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic regHit,
  input wire logic ffEventEn,
  input wire logic ffEventRaw,
  input wire logic ffEvent,
  input wire mep_pkg::mep_cfg_s cfg,
  input wire logic [15:0] ffDelayMs,
  input wire logic [15:0] shkDelayMs,
  input wire logic [15:0] knkQuietMs,
  input wire logic [15:0] knkShockMs,
  input wire logic [4:0] knkSampleCount,
  input wire logic [2:0] motSampleCount,
  input wire logic [15:0] lvlHoldMs
);
  import mep_pkg::*;
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ff_gated: assert property (ffEventRaw && ffEventEn |=> ffEvent)
    else $error("freefall event lost");
  a_ff_blocked: assert property (!ffEventEn |=> !ffEvent)
    else $error("freefall event while disabled");
  a_ff_delay_ms: assert property (ffDelayMs == (16'(cfg.ffDelay) + 16'h1) * 16'h2)
    else $error("freefall delay wrong");
  a_shock_delay_ms: assert property (shkDelayMs == (16'(cfg.shkDelay) + 16'h1) * 16'h2)
    else $error("shock delay wrong");
  a_quiet_ms: assert property (knkQuietMs == (cfg.knkQuietShort ? 16'h14 : 16'h1e))
    else $error("quiet time wrong");
  a_shock_ms: assert property (knkShockMs == (cfg.knkShockLong ? 16'h4b : 16'h32))
    else $error("shock time wrong");
  a_motion_count: assert property (motSampleCount == 3'(cfg.motCount) + 3'h1)
    else $error("motion sample count wrong");
  a_knock_samples: assert property (knkSampleCount == (5'h2 << cfg.knkSamples))
    else $error("knock sample count wrong");
  a_hold_ms: assert property (lvlHoldMs == (cfg.lvlHold == 2'h0 ? 16'h0 : 16'h100 << cfg.lvlHold))
    else $error("hold time wrong");
  // Reserved and foreign addresses must answer with nothing
  a_unmapped_read: assert property (regRd && (regAddr == 8'h29 || regAddr > 8'h2f
    || regAddr < 8'h22) |=> !regHit && regRdata == 8'h00)
    else $error("unmapped read answered");
  a_delay_write: assert property (regWr && regAddr == 8'h22 |=> cfg.ffDelay == $past(regWdata))
    else $error("delay write not taken");
endmodule : mep_regs_properties

bind mep_regs mep_regs_properties chk_u (.mclk(mclk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .regHit(regHit),
  .ffEventEn(ffEventEn), .ffEventRaw(ffEventRaw), .ffEvent(ffEvent), .cfg(cfg),
  .ffDelayMs(ffDelayMs), .shkDelayMs(shkDelayMs), .knkQuietMs(knkQuietMs),
  .knkShockMs(knkShockMs), .knkSampleCount(knkSampleCount),
  .motSampleCount(motSampleCount), .lvlHoldMs(lvlHoldMs));

// >>> tb/mep_regs_test.sv
// Self-checking bench for the motion parameter register bank
`timescale 1ns/1ns
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %s", $time, m); end end
module mep_regs_test;
  import mep_pkg::*;
  typedef struct packed {
    logic [7:0] data;
    logic hit;
  } mep_exp_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic ffEventEn = 1'b0;
  logic ffEventRaw = 1'b0;
  logic [7:0] regRdata;
  logic regHit;
  logic ffEvent;
  mep_cfg_s cfg;
  logic [15:0] ffDelayMs, shkDelayMs, knkQuietMs, knkShockMs, knkWindowMs, lvlHoldMs;
  logic [4:0] knkSampleCount;
  logic [2:0] motSampleCount;
  // Per offset 0x22..0x31: reset byte and writable bits
  logic [7:0] rstVal [16] = '{8'h09, 8'h30, 8'h81, 8'h0f, 8'hc0, 8'h00, 8'h14, 8'h00,
    8'h04, 8'h0a, 8'h18, 8'h08, 8'h08, 8'h10, 8'h00, 8'h00};
  logic [7:0] wrMask [16] = '{8'hff, 8'hff, 8'hc7, 8'hff, 8'hff, 8'h03, 8'hff, 8'h00,
    8'hc7, 8'hdf, 8'h7f, 8'h3f, 8'h3f, 8'h30, 8'h00, 8'h00};
  logic [15:0] winMs [8] = '{16'h0032, 16'h0064, 16'h0096, 16'h00c8, 16'h00fa, 16'h0177,
    16'h01f4, 16'h02bc};
  mep_exp_s expQ [$];
  mep_exp_s curExp;
  logic rdSeen = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;

  mep_regs dut_u (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .regHit(regHit),
    .ffEventEn(ffEventEn), .ffEventRaw(ffEventRaw), .ffEvent(ffEvent), .cfg(cfg),
    .ffDelayMs(ffDelayMs), .shkDelayMs(shkDelayMs), .knkQuietMs(knkQuietMs),
    .knkShockMs(knkShockMs), .knkWindowMs(knkWindowMs), .knkSampleCount(knkSampleCount),
    .motSampleCount(motSampleCount), .lvlHoldMs(lvlHoldMs));

  // 100 ns period
  always #50 mclk = ~mclk;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    regRd <= 1'b0;
  endtask : wr

  // The read's expected answer is noted as the strobe goes out
  task automatic rd(input logic [7:0] a, input mep_exp_s e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    regWr <= 1'b0;
    expQ.push_back(e);
  endtask : rd

  task automatic idle();
    @(posedge mclk);
    regRd <= 1'b0;
    regWr <= 1'b0;
  endtask : idle

  task automatic close_out();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Read data stands only in the cycle after the strobe, so sample it there
  always @(posedge mclk)
  begin
    if (rdSeen)
    begin
      curExp = expQ.pop_front();
      `CHK(regRdata, curExp.data, "read data")
      `CHK(regHit, curExp.hit, "hit flag")
    end
    rdSeen <= regRd && !rst;
  end

  // Hang guard well beyond the whole sequence
  initial
  begin
    #2000000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    int i;
    logic [7:0] d;
    void'($urandom(13));
    repeat (2)
    begin
      // Second pass checks that a mid-run reset restores every field
      rst <= 1'b1;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      for (i = 0; i < 16; i++)
        rd(8'h22 + 8'(i), {rstVal[i], 1'(i != 7 && i < 14)});
      // Write then read at once, reserved bits and places included
      repeat (3)
        for (i = 0; i < 16; i++)
        begin
          d = 8'($urandom);
          wr(8'h22 + 8'(i), d);
          rd(8'h22 + 8'(i), {d & wrMask[i], 1'(i != 7 && i < 14)});
        end
      // Addresses outside the bank take no write and answer with nothing
      wr(8'h21, 8'hff);
      rd(8'h21, {8'h00, 1'b0});
      rd(8'hc3, {8'h00, 1'b0});
      idle();
      // Let the last answer be taken before reset can wipe it
      repeat (2) @(posedge mclk);
    end
    // Every double-knock window code
    for (i = 0; i < 8; i++)
    begin
      wr(8'h2a, 8'(i));
      idle();
      @(negedge mclk);
      `CHK(knkWindowMs, winMs[i], "knock window")
    end
    // Freefall gate follows its enable one cycle later
    repeat (40)
    begin
      @(posedge mclk);
      d[0] = ffEventRaw & ffEventEn;
      ffEventEn <= 1'($urandom);
      ffEventRaw <= 1'($urandom);
      #1;
      `CHK(ffEvent, d[0], "freefall event")
    end
    repeat (3) @(posedge mclk);
    `CHK(expQ.size(), 0, "reads left unanswered")
    close_out();
  end
endmodule : mep_regs_test
